/* File: logic/afc_consts.vh */
// Operation
// RULE1: Randomizer XORs every data bit above bit 0 with bit 0.
// RULE2: Receiver XORs received bits above bit 0 with received bit 0.
// RULE3: Alternate polarity inverts odd data bits D1 to D13.
// RULE4: Receiver inverts odd data bits again to undo alternate polarity.
// RULE5: Randomizer and alternate polarity are independent controls.
// RULE6: Test patterns: all ones, all zeros, alternating, checkerboard.
// RULE7: An active test pattern bypasses all other formatting.
// RULE8: Output disable floats all data, overrange and clock outputs.
// RULE9: Host naps or sleeps both channels while outputs are disabled.
// RULE10: Sleep powers down the whole device; data invalid 2 ms after.
// RULE11: Nap powers down a core; wait 100 sample clocks after.
// RULE12: Host waits further 50 us after nap for accurate DC.
// RULE13: Nap only channel 2 or both; never channel 1 alone.
// RULE14: Strap mode treats serial pins as static mode inputs.
// RULE15: Strap chip-select level sets the duty cycle stabilizer.
// RULE16: Strap serial clock: low full-rate CMOS, high DDR LVDS.
// RULE17: Strap data pins form power code: normal, nap2, nap both, sleep.
// RULE18: Transfer framed by chip-select; only first 16 rising edges sampled.
// RULE19: Word is read/write bit, seven address bits, eight data bits.
// RULE20: Write stores byte; read returns register, ignores input, keeps it.
// RULE21: Serial output only pulls low; host provides pull-up.
// RULE22: Writing D7 of reset register clears all registers, self-clears.
// RULE23: Alternate polarity forces offset binary coding.
// RULE24: Test field: 000 off, 001 zeros, 011 ones, 101 checker, 111 alt.
// RULE25: Reset register is write-only; reset briefly puts device asleep.
// RULE26: Randomizer applies before odd-bit inversion.
// RULE27: Read data leaves MSB first over the last eight serial clocks.
`ifndef AFC_CONSTS_VH
`define AFC_CONSTS_VH
`define AFC_ADDR_RESET   7'h00
`define AFC_ADDR_POWER   7'h01
`define AFC_ADDR_TIMING  7'h02
`define AFC_ADDR_OUTMODE 7'h03
`define AFC_ADDR_FORMAT  7'h04
`define AFC_RESET_BIT    7
`define AFC_FMT_TWOS     0
`define AFC_FMT_RAND     1
`define AFC_FMT_ABP      2
`define AFC_FMT_TEST_LO  3
`define AFC_OUT_OFF_BIT  2
`define AFC_TEST_OFF     3'h0
`define AFC_TEST_ZEROS   3'h1
`define AFC_TEST_ONES    3'h3
`define AFC_TEST_CHECK   3'h5
`define AFC_TEST_ALT     3'h7
`define AFC_CHECK_A      15'h5555
`define AFC_CHECK_B      15'h2AAA
`define AFC_PWR_NORMAL   2'h0
`define AFC_PWR_NAP2     2'h1
`define AFC_PWR_NAPBOTH  2'h2
`define AFC_PWR_SLEEP    2'h3
`define AFC_WORD_BITS    16
`define AFC_RST_SLEEP_CYC 4'h4
`endif

/* File: logic/afc_pair_buf.v */
`timescale 1ns/1ps
`default_nettype none
// Two-entry skid buffer so a receiver stall loses no word
module afc_pair_buf #(
  parameter W = 15
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         ce_i,
  input  wire [W-1:0] in_data_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  output wire [W-1:0] out_data_o,
  output wire         out_valid_o,
  input  wire         out_ready_i
);
  reg [W-1:0] mem_q [0:1];
  reg         wp_q;
  reg         rp_q;
  reg [1:0]   cnt_q;
  wire        push = in_valid_i && (cnt_q != 2'h2);
  wire        pop  = out_ready_i && (cnt_q != 2'h0);

  assign in_ready_o  = (cnt_q != 2'h2);
  assign out_valid_o = (cnt_q != 2'h0);
  assign out_data_o  = mem_q[rp_q];

  // Pointer and count bookkeeping
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else if (ce_i) begin
      if (push) begin
        mem_q[wp_q] <= in_data_i;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      if (push && !pop)
        cnt_q <= cnt_q + 2'h1;
      else if (pop && !push)
        cnt_q <= cnt_q - 2'h1;
    end
  end
endmodule
`default_nettype wire

/* File: logic/afc_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "afc_consts.vh"
// Output formatting and mode configuration of a dual converter
module afc_top #(
  parameter DW = 14
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          ce_i,
  input  wire          config_style_select_i,
  input  wire          cs_n_i,
  input  wire          sck_i,
  input  wire          sdi_i,
  input  wire          sdo_pin_i,
  output reg           sdo_o,
  output reg           sdo_oe_n_o,
  input  wire [DW-1:0] sample_i,
  input  wire          overrange_i,
  input  wire          sample_valid_i,
  output wire          sample_ready_o,
  output reg  [DW-1:0] data_o,
  output reg           overrange_flag_o,
  output reg           data_valid_o,
  input  wire          data_ready_i,
  output reg           sample_output_clock_o,
  output reg           out_oe_n_o,
  output reg           dcs_on_o,
  output reg  [1:0]    out_mode_o,
  output reg           nap_ch1_o,
  output reg           nap_ch2_o,
  output reg           sleep_o
);
  // Pin synchronisers; stage one feeds stage two only
  // Reset to the idle pin levels (serial mode, deselected, line pulled up)
  // so no false strap code or clock edge follows reset
  reg [4:0] s1_q;
  reg [4:0] s2_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= 5'h09;
      s2_q <= 5'h09;
    end else if (ce_i) begin
      s1_q <= {config_style_select_i, cs_n_i, sck_i, sdi_i, sdo_pin_i};
      s2_q <= s1_q;
    end
  end
  wire strap = s2_q[4];
  wire csn   = s2_q[3];
  wire sck   = s2_q[2];
  wire sdi   = s2_q[1];
  wire sdop  = s2_q[0];

  // Serial clock edge detection on the synchronised copy
  reg sck_q;
  always @(posedge clk_i) begin
    if (rst_i)
      sck_q <= 1'b0;
    else if (ce_i)
      sck_q <= sck;
  end
  wire sck_rise = sck && !sck_q;
  wire sck_fall = !sck && sck_q;

  // Configuration registers
  reg [7:0] pwr_q;
  reg [7:0] tim_q;
  reg [7:0] omode_q;
  reg [7:0] fmt_q;
  reg [3:0] rst_sleep_q;
  reg [4:0] bitcnt_q;
  reg [15:0] shift_q;
  reg [7:0] rd_q;
  reg       rd_act_q;

  wire [15:0] word = {shift_q[14:0], sdi};

  // Serial port: sample on the first 16 rising edges of the frame
  always @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q       <= 8'h00;
      tim_q       <= 8'h00;
      omode_q     <= 8'h00;
      fmt_q       <= 8'h00;
      rst_sleep_q <= 4'h0;
      bitcnt_q    <= 5'h00;
      shift_q     <= 16'h0000;
      rd_q        <= 8'h00;
      rd_act_q    <= 1'b0;
    end else if (ce_i) begin
      if (rst_sleep_q != 4'h0)
        rst_sleep_q <= rst_sleep_q - 4'h1;
      if (strap || csn) begin // RULE18
        bitcnt_q <= 5'h00;
        rd_act_q <= 1'b0;
      end else if (sck_rise && bitcnt_q < 5'd16) begin // RULE18
        shift_q  <= word;
        bitcnt_q <= bitcnt_q + 5'h01;
        // After the address, latch read data for the last eight clocks
        if (bitcnt_q == 5'd7 && shift_q[6]) begin // RULE19
          rd_act_q <= 1'b1;
          rd_q     <= rd_val_next(word[6:0]);
        end
        if (bitcnt_q == 5'd15 && !shift_q[14]) begin // RULE20
          case (word[14:8])
            `AFC_ADDR_RESET: begin
              if (word[`AFC_RESET_BIT]) begin // RULE22
                pwr_q       <= 8'h00;
                tim_q       <= 8'h00;
                omode_q     <= 8'h00;
                fmt_q       <= 8'h00;
                rst_sleep_q <= `AFC_RST_SLEEP_CYC; // RULE25
              end
            end
            `AFC_ADDR_POWER:   pwr_q   <= word[7:0];
            `AFC_ADDR_TIMING:  tim_q   <= word[7:0];
            `AFC_ADDR_OUTMODE: omode_q <= word[7:0];
            `AFC_ADDR_FORMAT:  fmt_q   <= word[7:0];
            default: ;
          endcase
        end
      end else if (sck_fall && rd_act_q && bitcnt_q >= 5'd9) begin
        rd_q <= {rd_q[6:0], 1'b1}; // RULE27
      end
    end
  end

  // Register lookup by address; reset register reads back zero here
  function [7:0] rd_val_next;
    input [6:0] a;
    begin
      case (a)
        `AFC_ADDR_POWER:   rd_val_next = pwr_q;
        `AFC_ADDR_TIMING:  rd_val_next = tim_q;
        `AFC_ADDR_OUTMODE: rd_val_next = omode_q;
        `AFC_ADDR_FORMAT:  rd_val_next = fmt_q;
        default:           rd_val_next = 8'h00; // RULE25
      endcase
    end
  endfunction

  // Effective modes from straps or registers
  wire [1:0] pcode  = strap ? {sdi, sdop} : pwr_q[1:0]; // RULE17 RULE14
  wire       dcs    = strap ? csn : tim_q[0]; // RULE15
  wire [1:0] omode  = strap ? {1'b0, sck} : omode_q[1:0]; // RULE16
  wire       oe_off = strap ? 1'b0 : omode_q[`AFC_OUT_OFF_BIT];
  wire       sleep  = (pcode == `AFC_PWR_SLEEP) || (rst_sleep_q != 4'h0); // RULE10
  wire [2:0] test   = strap ? 3'h0 : fmt_q[5:3];
  wire       f_abp  = !strap && fmt_q[`AFC_FMT_ABP];
  wire       f_rnd  = !strap && fmt_q[`AFC_FMT_RAND];
  wire       f_two  = !strap && fmt_q[`AFC_FMT_TWOS] && !f_abp; // RULE23

  // Mode outputs and open-drain serial output
  always @(posedge clk_i) begin
    if (rst_i) begin
      dcs_on_o   <= 1'b0;
      out_mode_o <= 2'h0;
      nap_ch1_o  <= 1'b0;
      nap_ch2_o  <= 1'b0;
      sleep_o    <= 1'b0;
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end else if (ce_i) begin
      dcs_on_o   <= dcs;
      out_mode_o <= omode;
      sleep_o    <= sleep;
      // Channel 1 naps only together with channel 2
      nap_ch2_o  <= (pcode == `AFC_PWR_NAP2) || (pcode == `AFC_PWR_NAPBOTH); // RULE11 RULE13
      nap_ch1_o  <= (pcode == `AFC_PWR_NAPBOTH); // RULE13
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= !(!strap && rd_act_q && !rd_q[7]); // RULE21
    end
  end

  // Formatting; test patterns override everything
  reg         alt_q;
  reg [DW:0]  fmt_word;
  reg [DW-1:0] d;
  integer     k;
  always @* begin
    d = sample_i;
    // Input is offset binary; two's complement flips the sign bit
    if (f_two)
      d[DW-1] = ~d[DW-1];
    if (f_rnd) begin
      for (k = 1; k < DW; k = k + 1)
        d[k] = d[k] ^ d[0]; // RULE1 RULE5 RULE26
    end
    if (f_abp) begin
      for (k = 1; k < DW; k = k + 2)
        d[k] = ~d[k]; // RULE3 RULE5
    end
    case (test) // RULE24
      `AFC_TEST_ZEROS: fmt_word = {(DW+1){1'b0}}; // RULE6 RULE7
      `AFC_TEST_ONES:  fmt_word = {(DW+1){1'b1}}; // RULE6
      `AFC_TEST_CHECK: fmt_word = alt_q ? `AFC_CHECK_B : `AFC_CHECK_A; // RULE6
      `AFC_TEST_ALT:   fmt_word = {(DW+1){alt_q}}; // RULE6
      default:         fmt_word = {overrange_i, d};
    endcase
  end

  // Pattern phase advances per accepted sample
  wire in_ready;
  always @(posedge clk_i) begin
    if (rst_i)
      alt_q <= 1'b0;
    else if (ce_i && sample_valid_i && in_ready)
      alt_q <= ~alt_q;
  end

  wire [DW:0] buf_data;
  wire        buf_valid;
  wire        take = buf_valid && (!data_valid_o || data_ready_i);
  assign sample_ready_o = in_ready;

  afc_pair_buf #(
    .W (DW + 1)
  ) u_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ce_i        (ce_i),
    .in_data_i   (fmt_word),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (in_ready),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (!data_valid_o || data_ready_i)
  );

  // Output stage; clock toggles with each delivered word
  always @(posedge clk_i) begin
    if (rst_i) begin
      data_o                <= {DW{1'b0}};
      overrange_flag_o      <= 1'b0;
      data_valid_o          <= 1'b0;
      sample_output_clock_o <= 1'b0;
      out_oe_n_o            <= 1'b0;
    end else if (ce_i) begin
      out_oe_n_o <= oe_off; // RULE8
      if (take) begin
        data_o                <= buf_data[DW-1:0];
        overrange_flag_o      <= buf_data[DW];
        data_valid_o          <= 1'b1;
        sample_output_clock_o <= ~sample_output_clock_o;
      end else if (data_ready_i) begin
        data_valid_o <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/afc_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks; mode registers are hidden, so straps and stream carry most
module afc_chk #(parameter DW = 14) (
  input wire logic          clk_i,
  input wire logic          rst_i,
  input wire logic          config_style_select_i,
  input wire logic          cs_n_i,
  input wire logic          sck_i,
  input wire logic          sdi_i,
  input wire logic          sdo_pin_i,
  input wire logic          sdo_o,
  input wire logic          sdo_oe_n_o,
  input wire logic          sample_valid_i,
  input wire logic          sample_ready_o,
  input wire logic [DW-1:0] data_o,
  input wire logic          data_valid_o,
  input wire logic          data_ready_i,
  input wire logic          dcs_on_o,
  input wire logic [1:0]    out_mode_o,
  input wire logic          nap_ch1_o,
  input wire logic          nap_ch2_o,
  input wire logic          sleep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Six edges cover the pin synchronisers plus the output register
  sequence strap_held(sig);
    (config_style_select_i && $stable(sig)) [*6];
  endsequence
  strap_dcs_a: assert property (strap_held(cs_n_i) |-> dcs_on_o == cs_n_i)
    else $error("stabilizer does not follow strap");
  strap_mode_a: assert property (strap_held(sck_i) |-> out_mode_o == {1'b0, sck_i})
    else $error("output mode does not follow strap");
  strap_power_a: assert property (
    strap_held({sdi_i, sdo_pin_i}) |-> sleep_o == (sdi_i & sdo_pin_i) &&
    ((sdi_i & sdo_pin_i) || (nap_ch1_o == sdi_i && nap_ch2_o == (sdi_i | sdo_pin_i))))
    else $error("power state does not follow strap");
  strap_quiet_a: assert property (config_style_select_i [*5] |-> sdo_oe_n_o)
    else $error("serial output driven in strap mode");
  sdo_low_a: assert property (!sdo_o)
    else $error("serial output drives high");
  idle_release_a: assert property (cs_n_i [*6] |-> sdo_oe_n_o)
    else $error("serial line held outside frame");
  nap_order_a: assert property (nap_ch1_o |-> nap_ch2_o)
    else $error("channel 1 naps alone");
  stall_hold_a: assert property (data_valid_o && !data_ready_i |=> data_valid_o && $stable(data_o))
    else $error("stalled word changed");
  word_soon_a: assert property (sample_valid_i && sample_ready_o |-> ##[1:3] data_valid_o)
    else $error("accepted sample not offered");
endmodule
bind afc_top afc_chk #(.DW(DW)) chk (.*);
`default_nettype wire

/* File: verification/afc_rx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Receiving logic: takes words, can stall, and undoes the randomizer and alternate polarity
module afc_rx_model #(parameter DW = 14) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic [DW-1:0] data_i,
  input  wire logic          ovr_i,
  input  wire logic          valid_i,
  input  wire logic          rand_i,
  input  wire logic          abp_i,
  input  wire logic          hold_i,
  input  wire logic          slow_i,
  output wire logic          ready_o,
  output var  logic          got_o,
  output var  logic [DW:0]   raw_o,
  output var  logic [DW-1:0] dec_o
);
  logic [1:0]    cnt_q;
  logic [DW-1:0] unabp;
  // Slow mode accepts one cycle in four, so the sender must hold its word
  assign ready_o = !hold_i && (!slow_i || cnt_q == 2'h3);
  // Reverse order of the sender: odd bits back first, then the XOR
  assign unabp = abp_i ? data_i ^ {(DW/2){2'b10}} : data_i;
  always_ff @(posedge clk_i) begin
    cnt_q <= rst_i ? 2'h0 : cnt_q + 2'h1;
    got_o <= valid_i && ready_o && !rst_i;
    if (valid_i && ready_o) begin
      raw_o <= {ovr_i, data_i};
      dec_o <= rand_i ? unabp ^ {{(DW-1){unabp[0]}}, 1'b0} : unabp;
    end
  end
endmodule
`default_nettype wire

/* File: verification/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "afc_consts.vh"
module testbench;
  logic clk_i = 1'b0, rst_i = 1'b1, config_style_select_i = 1'b0, cs_n_i = 1'b1;
  logic sck_i = 1'b0, sdi_i = 1'b0, sdo_strap = 1'b0, overrange_i = 1'b1;
  logic sample_valid_i = 1'b0, hold = 1'b0, slow = 1'b0, rnd = 1'b0, abp = 1'b0;
  logic ce = 1'b1;
  int sleep_cyc = 0;
  logic [13:0] sample_i = 14'h0000;
  int n_mismatch = 0, checks = 0, cyc = 0;
  wire logic sdo_o, sdo_oe_n_o, sample_ready_o, overrange_flag_o, data_valid_o, data_ready_i;
  wire logic sample_output_clock_o, out_oe_n_o, dcs_on_o, nap_ch1_o, nap_ch2_o, sleep_o, got;
  wire logic [13:0] data_o, dec;
  wire logic [14:0] raw;
  wire logic [1:0] out_mode_o;
  // Open-drain line with the host pull-up; straps drive the pin directly
  wire logic sdo_line = sdo_oe_n_o ? 1'b1 : sdo_o;
  wire logic sdo_pin_i = config_style_select_i ? sdo_strap : sdo_line;
  // Format code, then the two words a pair of samples may give, either order
  logic [37:0] rows [10] = '{{8'h00, 15'h6C35, 15'h6C35}, {8'h01, 15'h4C35, 15'h4C35},
    {8'h02, 15'h53CB, 15'h53CB}, {8'h04, 15'h469F, 15'h469F}, {8'h05, 15'h469F, 15'h469F},
    {8'h06, 15'h7961, 15'h7961}, {8'h0F, 15'h0000, 15'h0000}, {8'h1F, 15'h7FFF, 15'h7FFF},
    {8'h2F, 15'h5555, 15'h2AAA}, {8'h3F, 15'h0000, 15'h7FFF}};
  afc_top #(.DW(14)) DUT (.clk_i, .rst_i, .ce_i(ce), .config_style_select_i, .cs_n_i,
    .sck_i, .sdi_i, .sdo_pin_i, .sdo_o, .sdo_oe_n_o, .sample_i, .overrange_i,
    .sample_valid_i, .sample_ready_o, .data_o, .overrange_flag_o, .data_valid_o,
    .data_ready_i, .sample_output_clock_o, .out_oe_n_o, .dcs_on_o, .out_mode_o,
    .nap_ch1_o, .nap_ch2_o, .sleep_o);
  afc_rx_model #(.DW(14)) rx (.clk_i, .rst_i, .data_i(data_o), .ovr_i(overrange_flag_o),
    .valid_i(data_valid_o), .rand_i(rnd), .abp_i(abp), .hold_i(hold), .slow_i(slow),
    .ready_o(data_ready_i), .got_o(got), .raw_o(raw), .dec_o(dec));
  always #10 clk_i = ~clk_i;
  // Catches the short sleep pulse that a software reset gives
  always @(posedge clk_i) begin
    if (sleep_o === 1'b1) sleep_cyc++;
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end
  task automatic close_out;
    if (n_mismatch == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Serial clock half period is four system clocks (160 ns period)
  task automatic spi(input logic [15:0] w, input int n, output logic [7:0] rd);
    cs_n_i = 1'b0;
    tick(4);
    for (int i = 0; i < n; i++) begin
      sdi_i = (i < 16) ? w[15-i] : 1'b1;
      sck_i = 1'b0;
      tick(4);
      sck_i = 1'b1;
      tick(2);
      if (i >= 8 && i < 16) rd[15-i] = sdo_line;
      tick(2);
    end
    sck_i = 1'b0;
    tick(4);
    cs_n_i = 1'b1;
    tick(8);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    spi({1'b0, a, d}, 16, x);
  endtask
  task automatic send(input logic [13:0] s);
    sample_i = s;
    sample_valid_i = 1'b1;
    while (sample_ready_o !== 1'b1) tick(1);
    tick(1);
    sample_valid_i = 1'b0;
  endtask
  task automatic get(output logic [14:0] r, output logic [13:0] d);
    int k;
    k = 0;
    while (got !== 1'b1 && k < 50) begin
      tick(1);
      k++;
    end
    cmp(k < 50, 1'b1);
    r = raw;
    d = dec;
    tick(1);
  endtask
  initial begin
    logic [14:0] r, r2, e;
    logic [13:0] d;
    logic [7:0] x;
    int n;
    tick(5);
    rst_i = 1'b0;
    tick(3);
    cmp({sdo_oe_n_o, out_oe_n_o, data_valid_o, sleep_o, nap_ch2_o, dcs_on_o}, 16'h20);
    wr(`AFC_ADDR_RESET, 8'h80);
    foreach (rows[i]) begin
      wr(`AFC_ADDR_FORMAT, rows[i][37:30]);
      rnd = rows[i][31];
      abp = rows[i][32];
      send(14'h2C35);
      get(r, d);
      if (i < 6) cmp(d, (i == 1) ? 14'h0C35 : 14'h2C35);
      send(14'h2C35);
      get(r2, d);
      e = (r === rows[i][14:0]) ? rows[i][14:0] : rows[i][29:15];
      cmp(r, e);
      cmp(r2, (e === rows[i][14:0]) ? rows[i][29:15] : rows[i][14:0]);
    end
    wr(`AFC_ADDR_FORMAT, 8'h16);
    spi({1'b1, `AFC_ADDR_FORMAT, 8'hE9}, 16, x);
    cmp(x, 8'h16);
    spi({1'b1, `AFC_ADDR_FORMAT, 8'h00}, 16, x);
    cmp(x, 8'h16);
    for (int c = 0; c < 4; c++) begin
      wr(`AFC_ADDR_POWER, 8'(c));
      cmp({sleep_o, (c == 3) ? 2'b00 : {nap_ch1_o, nap_ch2_o}},
        {c == 3, c == 2, c == 1 || c == 2});
    end
    spi({1'b0, `AFC_ADDR_OUTMODE, 8'h05}, 18, x);
    cmp({out_oe_n_o, out_mode_o}, 3'h5);
    wr(`AFC_ADDR_TIMING, 8'h01);
    cmp(dcs_on_o, 1'b1);
    wr(`AFC_ADDR_POWER, 8'h00);
    tick(2600);
    n = sleep_cyc;
    wr(`AFC_ADDR_RESET, 8'h80);
    cmp({sleep_o, dcs_on_o, out_oe_n_o}, 3'h0);
    cmp(16'(sleep_cyc - n), `AFC_RST_SLEEP_CYC);
    spi({1'b1, `AFC_ADDR_FORMAT, 8'h00}, 16, x);
    cmp(x, 8'h00);
    config_style_select_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      cs_n_i = i[0];
      sck_i = i[1];
      {sdi_i, sdo_strap} = 2'(3 - i);
      tick(10);
      cmp({dcs_on_o, out_mode_o, sleep_o}, {i[0], 1'b0, i[1], i == 0});
    end
    config_style_select_i = 1'b0;
    cs_n_i = 1'b1;
    sck_i = 1'b0;
    tick(8);
    // Receiver stalls while words keep coming; none may be lost
    hold = 1'b1;
    sample_valid_i = 1'b1;
    n = 0;
    repeat (12) begin
      sample_i = 14'(n);
      overrange_i = n[0];
      if (sample_ready_o === 1'b1) n++;
      tick(1);
    end
    sample_valid_i = 1'b0;
    cmp({n >= 2, sample_ready_o}, 2'h2);
    hold = 1'b0;
    slow = 1'b1;
    for (int k = 0; k < n; k++) begin
      get(r, d);
      cmp(r, {k[0], 14'(k)});
    end
    tick(4);
    cmp({sample_ready_o, data_valid_o}, 2'h2);
    // Clock enable low freezes the port, so this write never lands
    ce = 1'b0;
    wr(`AFC_ADDR_POWER, 8'h03);
    ce = 1'b1;
    tick(6);
    cmp(sleep_o, 1'b0);
    close_out();
  end
endmodule
`default_nettype wire
